/* atc_pkg.sv */
// Constants for the accumulator to control register transfer decoder
package atc_pkg;

  localparam int unsigned ACC_W   = 4;
  localparam int unsigned OPC_W   = 10;
  localparam int unsigned NUM_TGT = 6;

  // Target indices within the select vector
  localparam int unsigned IDX_WAKE0 = 0;
  localparam int unsigned IDX_WAKE1 = 1;
  localparam int unsigned IDX_WAKE2 = 2;
  localparam int unsigned IDX_WAKE3 = 3;
  localparam int unsigned IDX_LCD1  = 4;
  localparam int unsigned IDX_LCD2  = 5;

  localparam logic [OPC_W-1:0] OP_WAKE0 = 10'h21B;
  localparam logic [OPC_W-1:0] OP_WAKE1 = 10'h214;
  localparam logic [OPC_W-1:0] OP_WAKE2 = 10'h215;
  localparam logic [OPC_W-1:0] OP_WAKE3 = 10'h216;
  localparam logic [OPC_W-1:0] OP_LCD1  = 10'h20A;
  localparam logic [OPC_W-1:0] OP_LCD2  = 10'h20B;

  localparam logic [ACC_W-1:0] CTL_RESET = 4'h0;

  // Every transfer in this group: one word, one cycle
  localparam int unsigned XFER_WORDS  = 1;
  localparam int unsigned XFER_CYCLES = 1;

endpackage

/* atc_ctl_reg.sv */
// One four-bit control register loaded from the accumulator
`timescale 1ns/1ps
`default_nettype none

module atc_ctl_reg #(
  parameter int unsigned WIDTH = atc_pkg::ACC_W
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output var  logic [WIDTH-1:0] value_q
);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      value_q <= atc_pkg::CTL_RESET;
    end
    else if (clk_en && wr_en)
    begin
      value_q <= wr_data;
    end
  end

endmodule
`default_nettype wire

/* atc_xfer_decode.sv */
// Decode and execute of accumulator to control register transfers
`timescale 1ns/1ps
`default_nettype none

module atc_xfer_decode #(
  parameter logic [9:0] OP_WAKE0 = atc_pkg::OP_WAKE0,
  parameter logic [9:0] OP_WAKE1 = atc_pkg::OP_WAKE1,
  parameter logic [9:0] OP_WAKE2 = atc_pkg::OP_WAKE2,
  parameter logic [9:0] OP_WAKE3 = atc_pkg::OP_WAKE3,
  parameter logic [9:0] OP_LCD1  = atc_pkg::OP_LCD1,
  parameter logic [9:0] OP_LCD2  = atc_pkg::OP_LCD2
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic       instr_valid,
  input  wire logic [9:0] opcode,
  input  wire logic [3:0] acc,
  output logic            xfer_hit,
  output logic            carry_we,
  output logic            skip_next,
  output var  logic       xfer_done_q,
  output logic      [3:0] wake_ctl0,
  output logic      [3:0] wake_ctl1,
  output logic      [3:0] wake_ctl2,
  output logic      [3:0] wake_ctl3,
  output logic      [3:0] lcd_ctl1,
  output logic      [3:0] lcd_ctl2
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // One-hot target select; zero for any opcode outside this group
  function automatic logic [5:0] atc_decode(input logic [9:0] op);
    logic [5:0] sel;
    sel = 6'h00;
    sel[atc_pkg::IDX_WAKE0] = (op == OP_WAKE0);
    sel[atc_pkg::IDX_WAKE1] = (op == OP_WAKE1);
    sel[atc_pkg::IDX_WAKE2] = (op == OP_WAKE2);
    sel[atc_pkg::IDX_WAKE3] = (op == OP_WAKE3);
    sel[atc_pkg::IDX_LCD1]  = (op == OP_LCD1);
    sel[atc_pkg::IDX_LCD2]  = (op == OP_LCD2);
    return sel;
  endfunction

  logic [5:0] wr_sel;
  logic [3:0] ctl_value [6];

  assign wr_sel   = instr_valid ? atc_decode(opcode) : 6'h00;
  assign xfer_hit = |wr_sel;
  // The hit ignores clk_en on purpose: a stalled cycle still shows the
  // decode, but nothing is written until clk_en is high again

  // The group never writes carry and never asks for a skip
  assign carry_we  = 1'b0;
  assign skip_next = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Target registers
  // One register per target keeps every write enable private

  for (genvar i = 0; i < atc_pkg::NUM_TGT; i++)
  begin : g_tgt
    atc_ctl_reg #(
      .WIDTH (atc_pkg::ACC_W)
    ) u_reg (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .wr_en    (wr_sel[i]),
      .wr_data  (acc),
      .value_q  (ctl_value[i])
    );
  end

  assign wake_ctl0 = ctl_value[atc_pkg::IDX_WAKE0];
  assign wake_ctl1 = ctl_value[atc_pkg::IDX_WAKE1];
  assign wake_ctl2 = ctl_value[atc_pkg::IDX_WAKE2];
  assign wake_ctl3 = ctl_value[atc_pkg::IDX_WAKE3];
  assign lcd_ctl1  = ctl_value[atc_pkg::IDX_LCD1];
  assign lcd_ctl2  = ctl_value[atc_pkg::IDX_LCD2];

  // Completion marker: one cycle after the accepted instruction
  // Held, not cleared, while clk_en is low, so a stall does not lose it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      xfer_done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      xfer_done_q <= xfer_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Load checks use the package opcodes; an override of the opcode
  // parameters must keep them in step

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_wake0_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_WAKE0
    |=> wake_ctl0 == $past(acc) && xfer_done_q)
    else $error("wake_ctl0 did not take the accumulator");

  a_wake1_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_WAKE1
    |=> wake_ctl1 == $past(acc))
    else $error("wake_ctl1 did not take the accumulator");

  a_wake2_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_WAKE2
    |=> wake_ctl2 == $past(acc) && $stable(wake_ctl0))
    else $error("wake_ctl2 did not take the accumulator");

  a_wake3_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_WAKE3
    |=> wake_ctl3 == $past(acc))
    else $error("wake_ctl3 did not take the accumulator");

  a_lcd1_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_LCD1
    |=> lcd_ctl1 == $past(acc) && $stable(lcd_ctl2))
    else $error("lcd_ctl1 did not take the accumulator");

  a_lcd2_load: assert property (
    clk_en && instr_valid && opcode == atc_pkg::OP_LCD2
    |=> lcd_ctl2 == $past(acc))
    else $error("lcd_ctl2 did not take the accumulator");

  a_no_carry_skip: assert property (
    xfer_hit |-> !carry_we && !skip_next)
    else $error("transfer touched carry or skip");

  a_hold_frozen: assert property (
    !clk_en || !xfer_hit
    |=> $stable(wake_ctl0) && $stable(wake_ctl1) && $stable(wake_ctl2)
        && $stable(wake_ctl3) && $stable(lcd_ctl1) && $stable(lcd_ctl2))
    else $error("control register changed without a transfer");

  ////////////////////////////////////////////////////////////////////////////
  // Per-target isolation: a write to one target must never leak into
  // another, which a shared enable or an overlapping decode would cause

  a_wake0_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_WAKE0])
    |=> $stable(wake_ctl0))
    else $error("wake_ctl0 changed without its own transfer");

  a_wake1_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_WAKE1])
    |=> $stable(wake_ctl1))
    else $error("wake_ctl1 changed without its own transfer");

  a_wake2_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_WAKE2])
    |=> $stable(wake_ctl2))
    else $error("wake_ctl2 changed without its own transfer");

  a_wake3_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_WAKE3])
    |=> $stable(wake_ctl3))
    else $error("wake_ctl3 changed without its own transfer");

  a_lcd1_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_LCD1])
    |=> $stable(lcd_ctl1))
    else $error("lcd_ctl1 changed without its own transfer");

  a_lcd2_hold: assert property (
    !(clk_en && wr_sel[atc_pkg::IDX_LCD2])
    |=> $stable(lcd_ctl2))
    else $error("lcd_ctl2 changed without its own transfer");

  // Two opcodes set equal by an override would load both targets at once
  a_sel_onehot: assert property (
    $onehot0(wr_sel))
    else $error("more than one target selected");

  ////////////////////////////////////////////////////////////////////////////
  // Completion marker

  a_done_pulse: assert property (
    clk_en
    |=> xfer_done_q == $past(xfer_hit))
    else $error("completion marker does not follow the transfer");

  a_done_frozen: assert property (
    !clk_en
    |=> $stable(xfer_done_q))
    else $error("completion marker moved while frozen");

  a_refused_quiet: assert property (
    clk_en && !instr_valid
    |=> !xfer_done_q)
    else $error("completion marker without a valid instruction");

  // Reset is asynchronous, so this one runs with the default disable lifted
  a_reset_clear: assert property (
    disable iff (1'b0)
    !nrst ##1 !nrst
    |-> wake_ctl0 == atc_pkg::CTL_RESET && wake_ctl1 == atc_pkg::CTL_RESET
        && wake_ctl2 == atc_pkg::CTL_RESET && wake_ctl3 == atc_pkg::CTL_RESET
        && lcd_ctl1 == atc_pkg::CTL_RESET && lcd_ctl2 == atc_pkg::CTL_RESET
        && !xfer_done_q)
    else $error("reset left a control register or the marker set");

  c_wake0_write: cover property (
    clk_en && instr_valid && opcode == atc_pkg::OP_WAKE0);
  c_lcd2_write: cover property (
    clk_en && instr_valid && opcode == atc_pkg::OP_LCD2);
  c_back_to_back: cover property (
    clk_en && xfer_hit ##1 clk_en && xfer_hit);
  c_frozen_hit: cover property (
    !clk_en && xfer_hit);
  c_unknown_op: cover property (
    clk_en && instr_valid && !xfer_hit);

endmodule
`default_nettype wire

/* tb_accumulator_to_control_reg_transfer.sv */
// Self-checking bench for the accumulator to control register decoder
`timescale 1ns/1ps
`default_nettype none

module tb_accumulator_to_control_reg_transfer;
  logic        core_clk    = 1'b0;
  logic        nrst        = 1'b0;
  logic        clk_en      = 1'b1;
  logic        instr_valid = 1'b0;
  logic [9:0]  opcode      = 10'h000;
  logic [3:0]  acc         = 4'h0;
  logic        xfer_hit;
  logic        carry_we;
  logic        skip_next;
  logic        xfer_done_q;
  logic [3:0]  rg [6];
  logic [3:0]  mdl [6]     = '{default: 4'h0};
  logic [9:0]  ops [6]     = '{atc_pkg::OP_WAKE0, atc_pkg::OP_WAKE1,
                               atc_pkg::OP_WAKE2, atc_pkg::OP_WAKE3,
                               atc_pkg::OP_LCD1, atc_pkg::OP_LCD2};
  logic [6:0]  q [$];
  logic [6:0]  note;
  logic [31:0] seed        = 32'h41;
  int          error_cnt   = 0;
  int          checks_done = 0;

  always #10 core_clk = ~core_clk;

  atc_xfer_decode dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .instr_valid(instr_valid), .opcode(opcode), .acc(acc),
    .xfer_hit(xfer_hit), .carry_we(carry_we), .skip_next(skip_next),
    .xfer_done_q(xfer_done_q), .wake_ctl0(rg[0]), .wake_ctl1(rg[1]),
    .wake_ctl2(rg[2]), .wake_ctl3(rg[3]), .lcd_ctl1(rg[4]),
    .lcd_ctl2(rg[5])
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_all;
    for (int i = 0; i < 6; i++) chk(rg[i], mdl[i]);
  endtask

  // Index 6 stands for an opcode outside the group
  task automatic issue(input int i, input logic v, input logic en);
    seed = xs(seed);
    acc = seed[3:0];
    opcode = (i < 6) ? ops[i] : 10'h3FF;
    instr_valid = v;
    clk_en = en;
    #1;
    chk({3'h0, xfer_hit}, {3'h0, v && i < 6});
    if (v && en && i < 6)
    begin
      q.push_back({i[2:0], acc});
      mdl[i] = acc;
    end
    @(negedge core_clk);
  endtask

  // The registered outputs only move on the rising edge, so the falling edge is settled
  always @(negedge core_clk)
    if (nrst)
    begin
      chk({2'h0, carry_we, skip_next}, 4'h0);
      chk({3'h0, xfer_done_q}, {3'h0, q.size() != 0});
      if (xfer_done_q === 1'b1)
      begin
        if (q.size() == 0)
          chk(4'hF, 4'h0);
        else
        begin
          note = q.pop_front();
          chk(rg[note[6:4]], note[3:0]);
        end
      end
    end

  task automatic results;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge core_clk);
    cmp_all();
    nrst = 1'b1;
    for (int k = 0; k < 18; k++)
      issue(k % 6, 1'b1, 1'b1);
    $display("test back_to_back done");
    for (int k = 0; k < 6; k++) issue(k, 1'b0, 1'b1);
    for (int k = 0; k < 6; k++) issue(k, 1'b1, 1'b0);
    issue(6, 1'b1, 1'b1);
    instr_valid = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(negedge core_clk);
    cmp_all();
    chk(q.size() == 0 ? 4'h0 : 4'h1, 4'h0);
    $display("test refused done");
    nrst = 1'b0;
    mdl = '{default: 4'h0};
    #1;
    cmp_all();
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    issue(2, 1'b1, 1'b1);
    instr_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp_all();
    chk(q.size() == 0 ? 4'h0 : 4'h1, 4'h0);
    $display("test mid_reset done");
    results();
  end
endmodule

`default_nettype wire
